// File: rtl/dpc_pin_ctrl.sv
// Pin control, clock-ratio detect and serial input of a stereo DAC
//
// Decided for this implementation: the AXI4-Lite interface to the registers and the placing of the registers.
`timescale 1ns/1ps
module dpc_pin_ctrl
    import dpc_pkg::*;
(
    input wire logic mclk,
    input wire logic rst,
    input wire logic ce,
    input wire logic enable_pin,
    input wire logic format_pin,
    input wire logic deemphasis_select_pin,
    input wire logic bit_clock,
    input wire logic frame_clock,
    input wire logic serial_audio_data,
    input wire logic [ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    output logic powered_up,
    output logic high_perf,
    output logic deemphasis_on,
    output logic converter_run,
    output logic mute,
    output logic [SAMPLE_W-1:0] left_sample,
    output logic [SAMPLE_W-1:0] right_sample,
    output logic sample_valid
);
    logic [PIN_W-1:0] pin_s1_reg, pin_s2_reg, pin_last_reg;
    logic powered_reg, high_perf_reg, deemphasis_select_pin_on_reg;
    logic [CNT_W-1:0] cnt_reg, ratio_reg;
    logic seen_reg, mute_reg;
    logic fr_last_reg, dsp_reg, word16_reg;
    logic [5:0] pos_reg, half_len_reg, dsp_pos_reg;
    dpc_mode_type mode_reg, mode_next;
    logic [RJ_W-1:0] rj_sh_reg;
    logic [SAMPLE_W-1:0] i2s_sh_reg, lr_word;
    logic [DSP_W-1:0] dsp_sh_reg;
    logic [SAMPLE_W-1:0] left_reg, right_reg;
    logic valid_reg;
    logic aw_full_reg, w_full_reg, bvalid_reg, rvalid_reg;
    logic [ADDR_W-1:0] awaddr_reg;
    logic [31:0] wdata_reg, rdata_reg, rd_data;
    logic [3:0] wstrb_reg;
    logic [1:0] bresp_reg, rresp_reg, rate_reg;
    logic rd_hit;

    function automatic logic ratio_ok(input logic [11:0] c,
                                      input logic [1:0] r);
        logic ok;
        int n;
        ok = 1'b0;
        n = (r == RATE_192K) ? N_192K : ((r == RATE_96K) ? N_96K : N_48K);
        for (int i = 0; i < RATIO_N; i++) begin
            if (i < n && c + RATIO_TOL >= RATIO_TAB[i]
                && c <= RATIO_TAB[i] + RATIO_TOL) begin
                ok = 1'b1;
            end
        end
        return ok;
    endfunction

    // Pins come from outside the mclk domain
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            pin_s1_reg <= '0;
            pin_s2_reg <= '0;
            pin_last_reg <= '0;
        end else if (ce) begin
            pin_s1_reg <= {serial_audio_data, frame_clock, bit_clock,
                           format_pin, deemphasis_select_pin, enable_pin};
            pin_s2_reg <= pin_s1_reg;
            pin_last_reg <= pin_s2_reg;
        end
    end

    wire en = pin_s2_reg[PIN_EN];
    wire en_rise = en & ~pin_last_reg[PIN_EN];
    wire deemphasis_select_pin_lvl = pin_s2_reg[PIN_DEEMPHASIS_SELECT_PIN];
    wire fmt = pin_s2_reg[PIN_FMT];
    wire bc_rise = pin_s2_reg[PIN_BCLK] & ~pin_last_reg[PIN_BCLK];
    wire fr_now = pin_s2_reg[PIN_FRAME];
    wire fr_rise_m = fr_now & ~pin_last_reg[PIN_FRAME];
    wire dat = pin_s2_reg[PIN_DATA];
    wire ok_now = ratio_ok(cnt_reg, rate_reg);

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            powered_reg <= 1'b0;
            high_perf_reg <= 1'b0;
            deemphasis_select_pin_on_reg <= 1'b0;
        end else if (ce) begin
            powered_reg <= en;
            if (en_rise) begin
                high_perf_reg <= deemphasis_select_pin_lvl;
            end
            deemphasis_select_pin_on_reg <= en & deemphasis_select_pin_lvl;
        end
    end

    // Master clocks per frame, measured rising edge to rising edge
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            cnt_reg <= '0;
            ratio_reg <= '0;
            seen_reg <= 1'b0;
            mute_reg <= 1'b1;
        end else if (ce) begin
            if (!en) begin
                cnt_reg <= '0;
                seen_reg <= 1'b0;
                mute_reg <= 1'b1;
            end else if (fr_rise_m) begin
                ratio_reg <= cnt_reg;
                cnt_reg <= 12'h001;
                seen_reg <= 1'b1;
                if (seen_reg) begin
                    mute_reg <= ~ok_now;
                end
            end else begin
                if (cnt_reg != CNT_MAX) begin
                    cnt_reg <= cnt_reg + 12'h001;
                end
                if (cnt_reg > RATIO_LIMIT) begin
                    mute_reg <= 1'b1;
                end
            end
        end
    end

    // Frame-clock levels seen at bit-clock rising edges
    wire fr_chg = fr_now != fr_last_reg;
    wire [5:0] pos_next = fr_chg ? 6'h01 :
        ((pos_reg == POS_MAX) ? POS_MAX : pos_reg + 6'h01);
    wire [5:0] dsp_pos_next = (fr_chg && fr_now) ? 6'h01 :
        ((dsp_pos_reg == POS_MAX) ? POS_MAX : dsp_pos_reg + 6'h01);
    wire [5:0] dsp_first = fmt ? DSPA_FIRST : DSPB_FIRST;
    wire [5:0] dsp_idx = dsp_pos_next - dsp_first;
    wire dsp_cap = dsp_pos_next >= dsp_first && dsp_idx <= DSP_LAST;
    wire i2s_cap = pos_next >= I2S_FIRST && pos_next <= I2S_LAST;

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            fr_last_reg <= 1'b0;
            pos_reg <= '0;
            dsp_pos_reg <= POS_MAX;
            half_len_reg <= '0;
            word16_reg <= 1'b0;
            dsp_reg <= 1'b0;
        end else if (ce) begin
            if (!en) begin
                pos_reg <= '0;
                dsp_pos_reg <= POS_MAX;
                half_len_reg <= '0;
                word16_reg <= 1'b0;
                dsp_reg <= 1'b0;
            end else if (bc_rise) begin
                fr_last_reg <= fr_now;
                pos_reg <= pos_next;
                dsp_pos_reg <= dsp_pos_next;
                if (fr_chg) begin
                    half_len_reg <= pos_reg;
                    word16_reg <= pos_reg == PACKED_LEN
                                  && half_len_reg == PACKED_LEN;
                    if (fr_last_reg) begin
                        dsp_reg <= pos_reg <= DSP_PULSE_MAX;
                    end
                end
            end
        end
    end

    always_comb begin
        case ({dsp_reg, fmt})
            2'b00: mode_next = MODE_RJ;
            2'b01: mode_next = MODE_I2S;
            2'b10: mode_next = MODE_DSPB;
            2'b11: mode_next = MODE_DSPA;
            default: mode_next = MODE_RJ;
        endcase
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            mode_reg <= MODE_RJ;
        end else if (ce) begin
            mode_reg <= mode_next;
        end
    end

    // Word ending at this frame change; packed I2S LSB lands after it
    always_comb begin
        lr_word = i2s_sh_reg;
        case (mode_reg)
            MODE_RJ: lr_word = {rj_sh_reg, 8'h00};
            MODE_I2S: begin
                if (word16_reg) begin
                    lr_word[PACKED_LSB] = dat;
                end
            end
            default: lr_word = i2s_sh_reg;
        endcase
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            rj_sh_reg <= '0;
            i2s_sh_reg <= '0;
            dsp_sh_reg <= '0;
            left_reg <= '0;
            right_reg <= '0;
            valid_reg <= 1'b0;
        end else if (ce) begin
            valid_reg <= 1'b0;
            if (!en) begin
                i2s_sh_reg <= '0;
                left_reg <= '0;
                right_reg <= '0;
            end else if (bc_rise) begin
                rj_sh_reg <= {rj_sh_reg[RJ_W-2:0], dat};
                if (i2s_cap) begin
                    // Bits past the 24th are dropped
                    i2s_sh_reg[5'(I2S_LAST - pos_next)] <= dat;
                end
                if (dsp_cap) begin
                    dsp_sh_reg <= {dsp_sh_reg[DSP_W-2:0], dat};
                end
                if (fr_chg && (mode_reg == MODE_RJ || mode_reg == MODE_I2S))
                begin
                    i2s_sh_reg <= '0;
                    // Left is high in right justified, low in I2S
                    if (fr_last_reg == (mode_reg == MODE_RJ)) begin
                        left_reg <= mute_reg ? '0 : lr_word;
                    end else begin
                        right_reg <= mute_reg ? '0 : lr_word;
                        valid_reg <= ~mute_reg;
                    end
                end
                if ((mode_reg == MODE_DSPA || mode_reg == MODE_DSPB)
                    && dsp_cap && dsp_idx == DSP_LAST) begin
                    left_reg <= mute_reg ? '0 :
                        {dsp_sh_reg[DSP_W-2:RJ_W-1], 8'h00};
                    right_reg <= mute_reg ? '0 :
                        {dsp_sh_reg[RJ_W-2:0], dat, 8'h00};
                    valid_reg <= ~mute_reg;
                end
            end
        end
    end

    assign powered_up = powered_reg;
    assign high_perf = high_perf_reg;
    assign deemphasis_on = deemphasis_select_pin_on_reg;
    assign mute = mute_reg;
    assign converter_run = powered_reg & ~mute_reg;
    assign left_sample = left_reg;
    assign right_sample = right_reg;
    assign sample_valid = valid_reg;

    // AXI4-Lite slave
    assign s_axi_awready = ce & ~aw_full_reg & ~bvalid_reg;
    assign s_axi_wready = ce & ~w_full_reg & ~bvalid_reg;
    assign s_axi_arready = ce & ~rvalid_reg;
    assign s_axi_bvalid = bvalid_reg;
    assign s_axi_bresp = bresp_reg;
    assign s_axi_rvalid = rvalid_reg;
    assign s_axi_rdata = rdata_reg;
    assign s_axi_rresp = rresp_reg;

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            aw_full_reg <= 1'b0;
            w_full_reg <= 1'b0;
            bvalid_reg <= 1'b0;
            bresp_reg <= RESP_OKAY;
            awaddr_reg <= '0;
            wdata_reg <= '0;
            wstrb_reg <= '0;
            rate_reg <= CTRL_RESET;
        end else if (ce) begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_full_reg <= 1'b1;
                awaddr_reg <= {s_axi_awaddr[ADDR_W-1:2], 2'b00};
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_full_reg <= 1'b1;
                wdata_reg <= s_axi_wdata;
                wstrb_reg <= s_axi_wstrb;
            end
            if (aw_full_reg && w_full_reg && !bvalid_reg) begin
                aw_full_reg <= 1'b0;
                w_full_reg <= 1'b0;
                bvalid_reg <= 1'b1;
                bresp_reg <= (awaddr_reg <= ADDR_RIGHT) ? RESP_OKAY
                                                        : RESP_SLVERR;
                if (awaddr_reg == ADDR_CTRL && wstrb_reg[0]) begin
                    rate_reg <= wdata_reg[1:0];
                end
            end else if (bvalid_reg && s_axi_bready) begin
                bvalid_reg <= 1'b0;
            end
        end
    end

    always_comb begin
        rd_hit = 1'b1;
        rd_data = '0;
        case ({s_axi_araddr[ADDR_W-1:2], 2'b00})
            ADDR_CTRL: rd_data[1:0] = rate_reg;
            ADDR_STATUS: begin
                rd_data[ST_POWERED] = powered_reg;
                rd_data[ST_HIGH_PERF] = high_perf_reg;
                rd_data[ST_DEEMPHASIS_SELECT_PIN] = deemphasis_select_pin_on_reg;
                rd_data[ST_MUTE] = mute_reg;
                rd_data[ST_DSP] = dsp_reg;
                rd_data[ST_WORD16] = word16_reg;
                rd_data[ST_I2S] = fmt;
            end
            ADDR_RATIO: rd_data[CNT_W-1:0] = ratio_reg;
            ADDR_LEFT: rd_data[SAMPLE_W-1:0] = left_reg;
            ADDR_RIGHT: rd_data[SAMPLE_W-1:0] = right_reg;
            default: rd_hit = 1'b0;
        endcase
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            rvalid_reg <= 1'b0;
            rdata_reg <= '0;
            rresp_reg <= RESP_OKAY;
        end else if (ce) begin
            if (s_axi_arvalid && s_axi_arready) begin
                rvalid_reg <= 1'b1;
                rdata_reg <= rd_data;
                rresp_reg <= rd_hit ? RESP_OKAY : RESP_SLVERR;
            end else if (rvalid_reg && s_axi_rready) begin
                rvalid_reg <= 1'b0;
            end
        end
    end

    default clocking @(posedge mclk); endclocking
    default disable iff (rst);

    hp_latch_a: assert property (ce && en_rise |=>
        high_perf == $past(deemphasis_select_pin_lvl)) else $error("high perf not latched");
    deemphasis_select_pin_live_a: assert property (ce && en && deemphasis_select_pin_lvl |=>
        deemphasis_on) else $error("de-emphasis not following pin");
    low_power_a: assert property (ce && !en |=>
        !powered_up && !converter_run && mute) else $error("not low power");
    bad_ratio_a: assert property (ce && en && fr_rise_m && seen_reg
        && !ok_now |=> mute && !converter_run) else $error("no mute");
    unmute_a: assert property (ce && en && fr_rise_m && seen_reg
        && ok_now |=> !mute) else $error("mute kept on good ratio");
    rate_limit_a: assert property (ce && en && fr_rise_m && seen_reg
        && rate_reg == RATE_192K && cnt_reg == RATIO_TAB[2] |=> mute)
        else $error("256 ratio accepted at top rate");
    ratio_log_a: assert property (ce && en && fr_rise_m |=>
        ratio_reg == $past(cnt_reg) && cnt_reg == 12'h001)
        else $error("ratio not recorded");
    dsp_detect_a: assert property (ce && en && bc_rise && fr_chg
        && fr_last_reg && pos_reg <= DSP_PULSE_MAX ##1 ce
        |=> mode_reg == (fmt ? MODE_DSPA : MODE_DSPB))
        else $error("short pulse did not select DSP");
    fmt_sel_a: assert property (ce && !dsp_reg |=>
        mode_reg == ($past(fmt) ? MODE_I2S : MODE_RJ))
        else $error("format pin ignored");
    packed_a: assert property (ce && en && bc_rise && fr_chg
        && pos_reg == PACKED_LEN && half_len_reg == PACKED_LEN |=> word16_reg)
        else $error("packed 16-bit not detected");
    valid_mute_a: assert property (sample_valid |-> !mute
        && $past(mute_reg) == 1'b0) else $error("sample passed while muted");

    unmute_c: cover property (mute ##1 !mute);
    dsp_c: cover property (dsp_reg && sample_valid);
    packed_c: cover property (word16_reg && sample_valid);
    i2s_c: cover property (mode_reg == MODE_I2S && sample_valid);
endmodule

// File: pkg/dpc_pkg.sv
// Constants and types for the DAC pin-control and clock-detect block
package dpc_pkg;
    localparam int PIN_W = 6;
    localparam int PIN_EN = 0;
    localparam int PIN_DEEMPHASIS_SELECT_PIN = 1;
    localparam int PIN_FMT = 2;
    localparam int PIN_BCLK = 3;
    localparam int PIN_FRAME = 4;
    localparam int PIN_DATA = 5;

    localparam int CNT_W = 12;
    localparam int RATIO_N = 6;
    localparam logic [11:0] RATIO_TAB [RATIO_N] = '{12'h080, 12'h0C0,
        12'h100, 12'h180, 12'h200, 12'h300};
    localparam logic [11:0] RATIO_TOL = 12'h008;
    localparam logic [11:0] RATIO_LIMIT = 12'h308;
    localparam logic [11:0] CNT_MAX = 12'hFFF;
    localparam logic [1:0] RATE_48K = 2'h0;
    localparam logic [1:0] RATE_96K = 2'h1;
    localparam logic [1:0] RATE_192K = 2'h2;
    localparam int N_48K = 6;
    localparam int N_96K = 4;
    localparam int N_192K = 2;

    localparam int SAMPLE_W = 24;
    localparam int RJ_W = 16;
    localparam int DSP_W = 32;
    localparam logic [5:0] POS_MAX = 6'h3F;
    localparam logic [5:0] DSP_PULSE_MAX = 6'h04;
    localparam logic [5:0] PACKED_LEN = 6'h10;
    localparam logic [5:0] I2S_FIRST = 6'h02;
    localparam logic [5:0] I2S_LAST = 6'h19;
    localparam logic [4:0] PACKED_LSB = 5'h08;
    localparam logic [5:0] DSPA_FIRST = 6'h02;
    localparam logic [5:0] DSPB_FIRST = 6'h01;
    localparam logic [5:0] DSP_LAST = 6'h1F;

    localparam int ADDR_W = 8;
    localparam logic [7:0] ADDR_CTRL = 8'h00;
    localparam logic [7:0] ADDR_STATUS = 8'h04;
    localparam logic [7:0] ADDR_RATIO = 8'h08;
    localparam logic [7:0] ADDR_LEFT = 8'h0C;
    localparam logic [7:0] ADDR_RIGHT = 8'h10;
    localparam logic [1:0] CTRL_RESET = 2'h0;
    localparam int ST_POWERED = 0;
    localparam int ST_HIGH_PERF = 1;
    localparam int ST_DEEMPHASIS_SELECT_PIN = 2;
    localparam int ST_MUTE = 3;
    localparam int ST_DSP = 4;
    localparam int ST_WORD16 = 5;
    localparam int ST_I2S = 6;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef enum logic [3:0] {
        MODE_RJ = 4'h1,
        MODE_I2S = 4'h2,
        MODE_DSPA = 4'h4,
        MODE_DSPB = 4'h8
    } dpc_mode_type;
endpackage

// File: sim/dpc_src_model.sv
// Behavioural audio source driving the serial link pins
`timescale 1ns/1ps
module dpc_src_model (
    input wire logic run,
    input wire logic fmt,
    input wire logic dsp,
    input wire logic [7:0] half_bits,
    input wire logic [7:0] stretch,
    input wire logic [23:0] left_word,
    input wire logic [23:0] right_word,
    output logic bit_clock,
    output logic frame_clock,
    output logic serial_audio_data
);
    int seed = 32'ha34c80ee;
    logic carry = 1'b0;
    // Positions outside the word carry noise, like a longer word
    function automatic logic sbit(logic [23:0] w, int p);
        if (p < 0 || p > 23)
            return 1'($random(seed));
        return w[23-p];
    endfunction
    // Frame and data move half a bit ahead of the sampling rise
    task automatic send(logic f, logic d);
        frame_clock = f;
        serial_audio_data = d;
        #160 bit_clock = 1'b1;
        #160 bit_clock = 1'b0;
    endtask
    initial begin
        logic [23:0] w;
        int n;
        int p;
        bit_clock = 1'b0;
        frame_clock = 1'b0;
        serial_audio_data = 1'b0;
        #7;
        forever begin
            n = int'(half_bits);
            if (!run) begin
                // Link clock stands still, data line wanders
                serial_audio_data = ~serial_audio_data;
                #320;
            end else if (dsp) begin
                for (int k = 0; k < 64; k++) begin
                    // Mode B MSB shares the pulse bit, mode A one bit later
                    p = k - int'(fmt);
                    w = p < 16 ? left_word : right_word;
                    send(k == 0, sbit(w, p < 16 ? p : p - 16));
                end
            end else begin
                for (int h = 0; h < 2; h++) begin
                    w = (h[0] != fmt) ? left_word : right_word;
                    for (int k = 1; k <= n; k++) begin
                        p = fmt ? k - 2 : k - 1 - (n - 16);
                        send(h[0], (fmt && p < 0) ? carry : sbit(w, p));
                    end
                    carry = sbit(w, n - 1);
                end
            end
            if (run)
                #(stretch * 40);
        end
    end
endmodule

// File: sim/tb.sv
// Self-checking bench for the DAC pin-control and clock-detect block
`timescale 1ns/1ps
module tb;
    import dpc_pkg::*;
    logic mclk = 1'b0;
    logic rst = 1'b1;
    logic en = 1'b0, fmt = 1'b1, deem = 1'b1, run = 1'b0, dsp = 1'b0;
    logic chk = 1'b0;
    logic [7:0] half_bits = 8'h20, stretch = 8'h00;
    logic [7:0] awaddr = 8'h00, araddr = 8'h00;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
    logic arvalid = 1'b0, rready = 1'b0;
    logic [31:0] wdata = 32'h0000_0000;
    logic awready, wready, bvalid, arready, rvalid;
    logic [1:0] bresp, rresp;
    logic [31:0] rdata, rq;
    logic pwr, hp, dem_on, crun, mute, sval, bck, fck, sd;
    logic [23:0] lsam, rsam, lw = 24'h00_0000, rw = 24'h00_0000;
    int seed = 32'ha34c80ee;
    int err_count = 0;
    int comparisons = 0;
    int nval = 0;
    always #20 mclk = ~mclk;
    dpc_pin_ctrl dpc_pin_ctrl_inst (.mclk(mclk), .rst(rst), .ce(1'b1),
        .enable_pin(en), .format_pin(fmt), .deemphasis_select_pin(deem),
        .bit_clock(bck), .frame_clock(fck), .serial_audio_data(sd),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF),
        .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
        .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
        .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
        .s_axi_rvalid(rvalid), .s_axi_rready(rready), .powered_up(pwr),
        .high_perf(hp), .deemphasis_on(dem_on), .converter_run(crun),
        .mute(mute), .left_sample(lsam), .right_sample(rsam),
        .sample_valid(sval));
    dpc_src_model dpc_src_model_inst (.run(run), .fmt(fmt), .dsp(dsp),
        .half_bits(half_bits), .stretch(stretch), .left_word(lw),
        .right_word(rw), .bit_clock(bck), .frame_clock(fck),
        .serial_audio_data(sd));
    task automatic check(string what, logic [31:0] seen, logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            err_count++;
            $display("BAD %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic final_report;
        $display("comparisons %0d mismatches %0d", comparisons, err_count);
        if (err_count == 0 && comparisons > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    // 16-bit words sit in the top bits with a zero low byte
    function automatic logic [23:0] ex(logic [23:0] w);
        return (dsp || half_bits == 8'h10 || !fmt) ? {w[23:8], 8'h00} : w;
    endfunction
    task automatic wr(logic [7:0] a, logic [31:0] d, logic [1:0] er);
        int t = 0;
        @(posedge mclk);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do begin
            @(posedge mclk);
            t++;
            if (awready)
                awvalid <= 1'b0;
            if (wready)
                wvalid <= 1'b0;
        end while (!bvalid && t < 200);
        bready <= 1'b0;
        check("bvalid", 32'(bvalid), 32'h0000_0001);
        check("bresp", 32'(bresp), 32'(er));
    endtask
    task automatic rd(logic [7:0] a, logic [1:0] er);
        int t = 0;
        @(posedge mclk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do begin
            @(posedge mclk);
            t++;
            if (arready)
                arvalid <= 1'b0;
        end while (!rvalid && t < 200);
        rq = rdata;
        rready <= 1'b0;
        check("rvalid", 32'(rvalid), 32'h0000_0001);
        check("rresp", 32'(rresp), 32'(er));
    endtask
    task automatic play(string name, int pre, int win, logic em);
        @(posedge mclk);
        lw <= 24'($random(seed));
        rw <= 24'($random(seed));
        repeat (pre * 520) @(posedge mclk);
        nval = 0;
        chk <= 1'b1;
        repeat (win * 520) @(posedge mclk);
        chk <= 1'b0;
        check({name, " mute"}, 32'(mute), 32'(em));
        check({name, " pairs"}, 32'(em ? nval == 0 : nval >= win - 1), 32'h1);
        $display("test %s done", name);
    endtask
    always @(posedge mclk) begin
        if (sval === 1'b1) begin
            nval++;
            if (chk) begin
                check("left", 32'(lsam), 32'(ex(lw)));
                check("right", 32'(rsam), 32'(ex(rw)));
            end
        end
    end
    initial begin
        repeat (2) @(posedge mclk);
        rst <= 1'b0;
        @(posedge mclk);
        check("reset", 32'({mute, pwr}), 32'h0000_0002);
        rd(ADDR_CTRL, RESP_OKAY);
        check("ctrl reset", rq, 32'(CTRL_RESET));
        run <= 1'b1;
        repeat (600) @(posedge mclk);
        en <= 1'b1;
        repeat (10) @(posedge mclk);
        check("enable", 32'({pwr, hp, dem_on}), 32'h0000_0007);
        deem <= 1'b0;
        repeat (10) @(posedge mclk);
        check("deemphasis_select_pin", 32'({hp, dem_on}), 32'h0000_0002);
        play("i2s", 3, 3, 1'b0);
        check("run", 32'(crun), 32'h0000_0001);
        rd(ADDR_RATIO, RESP_OKAY);
        check("ratio", 32'(rq[11:0]), 32'h0000_0200);
        rd(ADDR_STATUS, RESP_OKAY);
        check("status", 32'(rq[6:0]), 32'h0000_0043);
        rd(8'h14, RESP_SLVERR);
        wr(8'h14, 32'h0000_0001, RESP_SLVERR);
        wr(ADDR_STATUS, 32'h0000_00FF, RESP_OKAY);
        rd(ADDR_STATUS, RESP_OKAY);
        check("status ro", 32'(rq[6:0]), 32'h0000_0043);
        for (int h = 0; h < 2; h++) begin
            half_bits <= h ? 8'h10 : 8'h20;
            for (int c = 0; c < 4; c++) begin
                wr(ADDR_CTRL, 32'(c), RESP_OKAY);
                play("rate", 3, 3, h ? c == 2 : c == 1 || c == 2);
            end
        end
        wr(ADDR_CTRL, 32'h0000_0000, RESP_OKAY);
        half_bits <= 8'h20;
        fmt <= 1'b0;
        play("rj", 3, 3, 1'b0);
        for (int f = 0; f < 2; f++) begin
            fmt <= f[0];
            dsp <= 1'b1;
            play("dsp", 4, 3, 1'b0);
            rd(ADDR_STATUS, RESP_OKAY);
            check("dsp flag", 32'(rq[4]), 32'h0000_0001);
        end
        dsp <= 1'b0;
        fmt <= 1'b1;
        for (int s = 0; s < 3; s++) begin
            stretch <= s == 0 ? 8'h06 : s == 1 ? 8'h0E : 8'h00;
            play("tolerance", 3, 3, s == 1);
        end
        en <= 1'b0;
        repeat (10) @(posedge mclk);
        check("off", 32'({pwr, mute, crun, hp}), 32'h0000_0005);
        run <= 1'b0;
        repeat (600) @(posedge mclk);
        run <= 1'b1;
        repeat (600) @(posedge mclk);
        en <= 1'b1;
        repeat (10) @(posedge mclk);
        check("relatch", 32'({pwr, hp}), 32'h0000_0002);
        $display("test enable done");
        final_report;
    end
    initial begin
        repeat (90000) @(posedge mclk);
        err_count++;
        final_report;
    end
endmodule
